// ### dv/osc_partner_model.sv
// Behavioural model of the oscillators and analog status around the clock select block
`timescale 1ns/1ps
module osc_partner_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Controls from the block
	input wire logic primary_drive,
	input wire logic sec_osc_enable,
	// Oscillator outputs and status
	output logic primary_osc_level,
	output logic sec_osc_ready,
	output logic hf_stable_in,
	output logic mf_stable_in,
	output logic lf_stable_in
);
	logic [1:0] phase;
	logic [5:0] warm;
	logic [4:0] sec_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// Crystal runs at a quarter of aclk while driven, secondary needs a warm-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= 2'h0;
			warm <= 6'h00;
			sec_cnt <= 5'h00;
		end else begin
			phase <= primary_drive ? phase + 2'h1 : 2'h0;
			if (warm != 6'h3F) begin
				warm <= warm + 6'h01;
			end
			if (!sec_osc_enable) begin
				sec_cnt <= 5'h00;
			end else if (sec_cnt != 5'h1F) begin
				sec_cnt <= sec_cnt + 5'h01;
			end
		end
	end

	assign primary_osc_level = phase[1];
	assign sec_osc_ready = (sec_cnt == 5'h1F);
	assign hf_stable_in = (warm == 6'h3F);
	assign mf_stable_in = (warm == 6'h3F);
	assign lf_stable_in = (warm == 6'h3F);
endmodule : osc_partner_model

// ### dv/system_clock_select_control_test.sv
// Self-checking testbench for the system clock select control block
`timescale 1ns/1ps
module system_clock_select_control_test;
	import clk_sel_pkg::*;
	logic aclk, aresetn, por_flag;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, primary_mode_cfg, int_div_shift;
	logic [1:0] bresp, rresp, int_osc_src;
	logic pll_cfg_fuse, two_speed_cfg, hf_s, mf_s, lf_s, sec_rdy, posc, pfail, sec_other;
	logic sleep_exec, wake_event, sys_clk_gate, pll_select, clkout_enable, sec_osc_enable;
	logic primary_drive, wdog_lf_select, idle_entry, sleep_entry;
	logic [2:0] sys_src_sel;
	logic [31:0] rv;
	logic [1:0] rs;
	logic gate_low;
	int fail_count, num_checks;
	logic [3:0] tm [8];
	logic [3:0] tf [8];

	system_clock_select_control system_clock_select_control_inst (.aclk(aclk),
		.aresetn(aresetn), .por_flag(por_flag), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.primary_mode_cfg(primary_mode_cfg), .pll_cfg_fuse(pll_cfg_fuse),
		.two_speed_cfg(two_speed_cfg), .hf_stable_in(hf_s), .mf_stable_in(mf_s),
		.lf_stable_in(lf_s), .sec_osc_ready(sec_rdy), .primary_osc_level(posc),
		.primary_clock_fail(pfail), .sec_osc_request_other(sec_other),
		.sleep_exec(sleep_exec), .wake_event(wake_event), .sys_src_sel(sys_src_sel),
		.sys_clk_gate(sys_clk_gate), .int_osc_src(int_osc_src), .int_div_shift(int_div_shift),
		.pll_select(pll_select), .clkout_enable(clkout_enable), .sec_osc_enable(sec_osc_enable),
		.primary_drive(primary_drive), .wdog_lf_select(wdog_lf_select),
		.idle_entry(idle_entry), .sleep_entry(sleep_entry));

	osc_partner_model osc_partner_model_inst (.aclk(aclk), .aresetn(aresetn),
		.primary_drive(primary_drive), .sec_osc_enable(sec_osc_enable),
		.primary_osc_level(posc), .sec_osc_ready(sec_rdy), .hf_stable_in(hf_s),
		.mf_stable_in(mf_s), .lf_stable_in(lf_s));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			fail_count++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic do_reset(input logic por);
		aresetn <= 1'b0;
		por_flag <= por;
		tick(16);
		aresetn <= 1'b1;
		por_flag <= 1'b0;
		tick(1);
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		int n;
		aw_done = 1'b0;
		w_done = 1'b0;
		n = 0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			n++;
			if (!aw_done && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
			if (bvalid === 1'b1 || n > 200) break;
		end
		rs = bresp;
		if (n > 200) fail_count++;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1 || n > 200) break;
		end
		rv = rdata;
		rs = rresp;
		if (n > 200) fail_count++;
	endtask : rd

	// Waits for the active source, noting whether the clock was gated on the way
	task automatic wait_src(input logic [2:0] exp);
		int n;
		gate_low = 1'b0;
		for (n = 0; n < 8000 && sys_src_sel !== exp; n++) begin
			@(posedge aclk);
			if (sys_clk_gate === 1'b0) gate_low = 1'b1;
		end
		chk({29'h0, sys_src_sel}, {29'h0, exp});
		tick(12);
		chk({31'h0, sys_clk_gate}, 32'h1);
	endtask : wait_src

	function automatic logic [5:0] exp_int(input logic mf, input logic s, input logic [2:0] c);
		if (c >= 3'h3) return {INT_HF, 4'(7 - c)};
		if (c != 3'h0) return mf ? {INT_MF, 4'(2 - c)} : {INT_HF, 4'(7 - c)};
		if (!s) return {INT_LF, 4'h0};
		return mf ? {INT_MF, 4'h4} : {INT_HF, 4'h9};
	endfunction : exp_int

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and tests
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		#500000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, sleep_exec, wake_event} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		{pll_cfg_fuse, two_speed_cfg, pfail, sec_other} = 4'h0;
		primary_mode_cfg = 4'h1;
		aresetn = 1'b0;
		por_flag = 1'b1;
		fail_count = 0;
		num_checks = 0;
		tm = '{4'h1, 4'h1, 4'h8, 4'h9, 4'h4, 4'h6, 4'h7, 4'hA};
		tf = '{4'hA, 4'h4, 4'h7, 4'h8, 4'h1, 4'h1, 4'h0, 4'h7};
		do_reset(1'b1);
		rd(8'h00); chk(rv & 32'hF3, 32'h30);
		rd(8'h04); chk(rv & 32'h3C, 32'h04);
		chk({31'h0, wdog_lf_select}, 32'h1);
		tick(2000);
		chk({31'h0, sys_src_sel === SRC_PRI}, 32'h0);
		wait_src(SRC_PRI);
		rd(8'h00); chk(rv & 32'h0C, 32'h0C);
		rd(8'h04); chk(rv & 32'hC3, 32'h03);
		rd(8'h0C); chk({rv[29:0], rs}, 32'h2); // unmapped read
		wr(8'h0C, 32'hFF); chk({30'h0, rs}, 32'h2); // unmapped write
		wr(8'h04, 32'h24); rd(8'h04); chk(rv & 32'h20, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(8'h00, 32'h30 | (i << 7));
			sleep_exec <= 1'b1;
			tick(1);
			sleep_exec <= 1'b0;
			#1 chk({30'h0, idle_entry, sleep_entry}, i ? 32'h2 : 32'h1);
			tick(1);
		end
		wr(8'h04, 32'h0C); tick(4); chk({31'h0, sec_osc_enable}, 32'h1);
		wr(8'h00, 32'h31); wait_src(SRC_SEC);
		chk({31'h0, gate_low}, 32'h1);
		rd(8'h04); chk(rv & 32'hC0, 32'h40);
		wr(8'h00, 32'h30); wait_src(SRC_PRI);
		sec_other <= 1'b1;
		wr(8'h04, 32'h04); tick(6); chk({31'h0, sec_osc_enable}, 32'h1);
		sec_other <= 1'b0;
		tick(6); chk({31'h0, sec_osc_enable}, 32'h0);
		wr(8'h00, 32'h32); wait_src(SRC_INT);
		rd(8'h00); chk(rv & 32'h0B, 32'h02);
		wr(8'h04, 32'h00); tick(2); chk({31'h0, primary_drive}, 32'h0);
		for (int m = 0; m < 2; m++) begin
			wr(8'h04, m << 4);
			for (int s = 0; s < 2; s++) begin
				wr(8'h08, s << 7);
				for (int c = 0; c < 8; c++) begin
					wr(8'h00, 32'h02 | (c << 4));
					tick(3);
					chk({int_osc_src, int_div_shift}, exp_int(m, s, c));
				end
			end
		end
		wr(8'h04, 32'h0C);
		do_reset(1'b0);
		rd(8'h04); chk(rv & 32'h08, 32'h08);
		rd(8'h00); chk(rv & 32'h73, 32'h30);
		do_reset(1'b1);
		rd(8'h04); chk(rv & 32'h08, 32'h00);
		wait_src(SRC_PRI);
		for (int i = 0; i < 8; i++) begin
			primary_mode_cfg <= tm[i];
			pll_cfg_fuse <= tf[i][3];
			wr(8'h08, {25'h0, tf[i][2], 6'h00});
			tick(20);
			chk({pll_select, clkout_enable}, tf[i][1:0]);
			rd(8'h04); chk(rv[7], tf[i][1]);
		end
		primary_mode_cfg <= 4'h1;
		pll_cfg_fuse <= 1'b0;
		wr(8'h08, 32'h00);
		tick(20);
		pfail <= 1'b1;
		wait_src(SRC_INT);
		rd(8'h08); chk(rv & 32'h01, 32'h01);
		// Two-speed boot runs on the internal block until the startup timer ends
		pfail <= 1'b0;
		two_speed_cfg <= 1'b1;
		do_reset(1'b1);
		tick(10);
		chk({29'h0, sys_src_sel}, {29'h0, SRC_INT});
		rd(8'h00);
		chk(rv & 32'h08, 32'h00);
		wait_src(SRC_PRI);
		rd(8'h00);
		chk(rv & 32'h08, 32'h08);
		// A wake-up restarts the startup timer, so the crystal is not taken back early
		wake_event <= 1'b1;
		tick(1);
		wake_event <= 1'b0;
		wr(8'h00, 32'h32);
		wait_src(SRC_INT);
		wr(8'h00, 32'h30);
		tick(2000);
		chk({31'h0, sys_src_sel === SRC_PRI}, 32'h0);
		wait_src(SRC_PRI);
		tally_and_finish();
	end
endmodule : system_clock_select_control_test

// ### rtl/clk_sel_pkg.sv
// Constants, encodings and register layout of the system clock select control block
package clk_sel_pkg;
	// Register byte offsets
	localparam logic [7:0] OSC_CTRL_OFS = 8'h00;
	localparam logic [7:0] OSC_CTRL2_OFS = 8'h04;
	localparam logic [7:0] OSC_TUNE_OFS = 8'h08;
	// Field positions
	localparam int IDLE_BIT = 7;
	localparam int IFS_LSB = 4;
	localparam int STARTUP_BIT = 3;
	localparam int HF_STABLE_BIT = 2;
	localparam int PLL_ACT_BIT = 7;
	localparam int SEC_RUN_BIT = 6;
	localparam int MF_SEL_BIT = 4;
	localparam int SEC_GO_BIT = 3;
	localparam int DRIVE_BIT = 2;
	localparam int MF_STABLE_BIT = 1;
	localparam int INT_SRC_BIT = 7;
	localparam int PLL_EN_BIT = 6;
	localparam int FAIL_BIT = 0;
	// Values after reset
	localparam logic [1:0] SYSCLK_SEL_RST = 2'h0;
	localparam logic [2:0] IFS_RST = 3'h3;
	localparam logic DRIVE_RST = 1'b1;
	// Source one-hot codes
	localparam logic [2:0] SRC_NONE = 3'h0;
	localparam logic [2:0] SRC_PRI = 3'h1;
	localparam logic [2:0] SRC_SEC = 3'h2;
	localparam logic [2:0] SRC_INT = 3'h4;
	// Internal oscillator choice
	localparam logic [1:0] INT_HF = 2'h0;
	localparam logic [1:0] INT_MF = 2'h1;
	localparam logic [1:0] INT_LF = 2'h2;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SWITCH_HOLD_NS = 40;
	localparam int SWITCH_HOLD_CYC = (SWITCH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OST_COUNT = 1024;
	localparam int BOOT_CYC = 3;
	localparam int SYNC_W = 13;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [4:0] {
		ST_BOOT = 5'b00001,
		ST_RUN = 5'b00010,
		ST_HOLD = 5'b00100,
		ST_WAIT = 5'b01000,
		ST_ENGAGE = 5'b10000
	} sw_state_e;
endpackage : clk_sel_pkg

// ### rtl/system_clock_select_control.sv
// System clock source select, internal frequency select and status with AXI4-Lite registers
`timescale 1ns/1ps
module system_clock_select_control
	import clk_sel_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_flag,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Configuration straps
	input wire logic [3:0] primary_mode_cfg,
	input wire logic pll_cfg_fuse,
	input wire logic two_speed_cfg,
	// Analog oscillator status
	input wire logic hf_stable_in,
	input wire logic mf_stable_in,
	input wire logic lf_stable_in,
	input wire logic sec_osc_ready,
	input wire logic primary_osc_level,
	input wire logic primary_clock_fail,
	input wire logic sec_osc_request_other,
	// Core events
	input wire logic sleep_exec,
	input wire logic wake_event,
	// Clock tree control
	output logic [2:0] sys_src_sel,
	output logic sys_clk_gate,
	output logic [1:0] int_osc_src,
	output logic [3:0] int_div_shift,
	output logic pll_select,
	output logic clkout_enable,
	output logic sec_osc_enable,
	output logic primary_drive,
	output logic wdog_lf_select,
	// Power management
	output logic idle_entry,
	output logic sleep_entry
);

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic prev_osc;
		sw_state_e state;
		logic [2:0] active;
		logic [3:0] hold_cnt;
		logic [10:0] ost_cnt;
		logic ost_done;
		logic fail_flag;
		logic [1:0] sysclk_sel;
		logic [2:0] int_freq_sel;
		logic idle_enable;
		logic mf_select;
		logic sec_osc_go;
		logic primary_drive_on;
		logic int_src_sel;
		logic pll_sw_enable;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] int_osc_src;
		logic [3:0] int_div_shift;
		logic pll_select;
		logic clkout_enable;
		logic sec_osc_enable;
		logic idle_entry;
		logic sleep_entry;
		logic sys_clk_gate;
	} state_s;

	state_s state_reg;
	state_s state_next;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	// Source, postscaler shift and oscillator for the internal block
	function automatic logic [5:0] decode_internal(input logic [2:0] ifs, input logic mf,
			input logic isrc);
		logic [1:0] src;
		logic [3:0] shift;
		src = INT_HF;
		shift = 4'h0;
		unique case (ifs)
			3'h7: shift = 4'h0;
			3'h6: shift = 4'h1;
			3'h5: shift = 4'h2;
			3'h4: shift = 4'h3;
			3'h3: shift = 4'h4;
			3'h2: begin
				src = mf ? INT_MF : INT_HF;
				shift = mf ? 4'h0 : 4'h5;
			end
			3'h1: begin
				src = mf ? INT_MF : INT_HF;
				shift = mf ? 4'h1 : 4'h6;
			end
			3'h0: begin
				src = !isrc ? INT_LF : (mf ? INT_MF : INT_HF);
				shift = !isrc ? 4'h0 : (mf ? 4'h4 : 4'h9);
			end
		endcase
		return {src, shift};
	endfunction : decode_internal

	// Modes: 0000 LP, 0001 XT, 001x HS, 010x EC, 011x RC, 1xxx internal
	function automatic logic mode_is_internal(input logic [3:0] mode);
		return mode[3];
	endfunction : mode_is_internal

	function automatic logic mode_needs_ost(input logic [3:0] mode);
		return mode[3:2] == 2'h0;
	endfunction : mode_needs_ost

	function automatic logic [2:0] sel_to_src(input logic [1:0] sel);
		return sel[1] ? SRC_INT : (sel[0] ? SRC_SEC : SRC_PRI);
	endfunction : sel_to_src

	function automatic logic two_speed_active(input logic [3:0] m, input logic ts);
		return ts && mode_needs_ost(m);
	endfunction : two_speed_active

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [3:0] mode;
	logic [5:0] int_dec;
	logic [2:0] desired;
	logic src_ready;
	logic wr_fire;
	logic [7:0] wr_byte;
	logic osc_rise;

	always_comb begin
		state_next = state_reg;
		mode = state_reg.sync2[3:0];
		osc_rise = state_reg.sync2[10] && !state_reg.prev_osc;
		wr_fire = 1'b0;
		wr_byte = 8'h00;

		// Two-flop synchronisers for straps and analog status
		state_next.sync1 = {sec_osc_request_other, primary_clock_fail, primary_osc_level,
			sec_osc_ready, lf_stable_in, mf_stable_in, hf_stable_in, two_speed_cfg,
			pll_cfg_fuse, primary_mode_cfg};
		state_next.sync2 = state_reg.sync1;
		state_next.prev_osc = state_reg.sync2[10];

		// Startup timer counts primary oscillations after boot or wake
		if (!mode_needs_ost(mode)) begin
			state_next.ost_done = 1'b1;
		end else if (!state_reg.ost_done && osc_rise) begin
			state_next.ost_cnt = state_reg.ost_cnt + 11'h001;
			if (state_reg.ost_cnt == 11'(OST_COUNT - 1)) begin
				state_next.ost_done = 1'b1;
			end
		end
		if (wake_event && mode_needs_ost(mode)) begin
			state_next.ost_cnt = 11'h000;
			state_next.ost_done = 1'b0;
		end

		desired = state_reg.fail_flag ? SRC_INT : sel_to_src(state_reg.sysclk_sel);
		unique case (desired)
			SRC_PRI: src_ready = state_reg.ost_done && state_reg.primary_drive_on;
			SRC_SEC: src_ready = state_reg.sync2[9];
			default: src_ready = 1'b1;
		endcase

		// Switch sequencer: gate off, wait for new source, engage
		state_next.hold_cnt = state_reg.hold_cnt - 4'h1;
		unique case (state_reg.state)
			ST_BOOT: begin
				if (state_reg.hold_cnt == 4'h0) begin
					state_next.state = ST_RUN;
					if (two_speed_active(mode, state_reg.sync2[5])) begin
						state_next.active = SRC_INT;
						state_next.state = ST_ENGAGE;
						state_next.hold_cnt = 4'(SWITCH_HOLD_CYC);
					end
				end
			end
			ST_RUN: begin
				state_next.hold_cnt = 4'(SWITCH_HOLD_CYC);
				if (desired != state_reg.active) begin
					state_next.state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (state_reg.hold_cnt == 4'h0) begin
					state_next.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				state_next.hold_cnt = 4'(SWITCH_HOLD_CYC);
				if (src_ready) begin
					state_next.active = desired;
					state_next.state = ST_ENGAGE;
				end
			end
			ST_ENGAGE: begin
				if (state_reg.hold_cnt == 4'h0) begin
					state_next.state = ST_RUN;
				end
			end
		endcase

		// AXI4-Lite write: address and data in either order
		if (awvalid && state_reg.awready) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = awaddr;
			state_next.awready = 1'b0;
		end
		if (wvalid && state_reg.wready) begin
			state_next.w_held = 1'b1;
			state_next.w_data = wdata[7:0];
			state_next.w_lane = wstrb[0];
			state_next.wready = 1'b0;
		end
		if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
			wr_fire = state_reg.w_lane;
			wr_byte = state_reg.w_data;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			unique case (state_reg.aw_addr)
				OSC_CTRL_OFS, OSC_CTRL2_OFS, OSC_TUNE_OFS: ;
				default: begin
					wr_fire = 1'b0;
					state_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.bvalid && bready) begin
			state_next.bvalid = 1'b0;
			state_next.awready = 1'b1;
			state_next.wready = 1'b1;
		end
		if (wr_fire) begin
			unique case (state_reg.aw_addr)
				OSC_CTRL_OFS: begin
					state_next.idle_enable = wr_byte[IDLE_BIT];
					state_next.int_freq_sel = wr_byte[IFS_LSB +: 3];
					state_next.sysclk_sel = wr_byte[1:0];
					state_next.fail_flag = 1'b0;
				end
				OSC_CTRL2_OFS: begin
					state_next.mf_select = wr_byte[MF_SEL_BIT];
					state_next.sec_osc_go = wr_byte[SEC_GO_BIT];
					state_next.primary_drive_on = wr_byte[DRIVE_BIT];
				end
				default: begin
					state_next.int_src_sel = wr_byte[INT_SRC_BIT];
					state_next.pll_sw_enable = wr_byte[PLL_EN_BIT];
				end
			endcase
		end

		// Fail-safe set after the software clear so that a loss in the same cycle wins
		if (state_reg.active == SRC_PRI && !mode_is_internal(mode)
				&& state_reg.sync2[11]) begin
			state_next.fail_flag = 1'b1;
		end

		// AXI4-Lite read
		if (arvalid && state_reg.arready) begin
			state_next.arready = 1'b0;
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			state_next.rdata = 32'h0000_0000;
			unique case (araddr)
				OSC_CTRL_OFS: state_next.rdata[7:0] = {state_reg.idle_enable,
					state_reg.int_freq_sel, state_reg.active == SRC_PRI,
					state_reg.sync2[6], state_reg.sysclk_sel};
				OSC_CTRL2_OFS: state_next.rdata[7:0] = {
					state_reg.pll_select && state_reg.active == SRC_PRI,
					state_reg.active == SRC_SEC, 1'b0, state_reg.mf_select,
					state_reg.sec_osc_go, state_reg.primary_drive_on,
					state_reg.sync2[7], state_reg.sync2[8]};
				OSC_TUNE_OFS: state_next.rdata[7:0] = {state_reg.int_src_sel,
					state_reg.pll_sw_enable, 5'h00, state_reg.fail_flag};
				default: state_next.rresp = RESP_SLVERR;
			endcase
		end
		if (state_reg.rvalid && rready) begin
			state_next.rvalid = 1'b0;
			state_next.arready = 1'b1;
		end

		// Registered clock tree controls
		int_dec = decode_internal(state_reg.int_freq_sel, state_reg.mf_select,
			state_reg.int_src_sel);
		state_next.int_osc_src = int_dec[5:4];
		state_next.int_div_shift = int_dec[3:0];
		state_next.pll_select = (!mode[3] && state_reg.sync2[4])
			|| (mode[3] && state_reg.pll_sw_enable);
		state_next.clkout_enable = (mode[3] || mode[2]) && !mode[0];
		state_next.sec_osc_enable = state_reg.sec_osc_go || state_reg.sync2[12]
			|| desired == SRC_SEC || state_reg.active == SRC_SEC;
		state_next.idle_entry = sleep_exec && state_reg.idle_enable;
		state_next.sleep_entry = sleep_exec && !state_reg.idle_enable;

		if (!aresetn) begin
			state_next = '0;
			state_next.state = ST_BOOT;
			state_next.hold_cnt = 4'(BOOT_CYC);
			state_next.sysclk_sel = SYSCLK_SEL_RST;
			state_next.int_freq_sel = IFS_RST;
			state_next.primary_drive_on = DRIVE_RST;
			state_next.sec_osc_go = por_flag ? 1'b0 : state_reg.sec_osc_go;
			state_next.awready = 1'b1;
			state_next.wready = 1'b1;
			state_next.arready = 1'b1;
		end
		state_next.sys_clk_gate = state_next.state == ST_RUN
			&& state_next.active != SRC_NONE;
	end

	always_ff @(posedge aclk) begin
		state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign awready = state_reg.awready;
	assign wready = state_reg.wready;
	assign bvalid = state_reg.bvalid;
	assign bresp = state_reg.bresp;
	assign arready = state_reg.arready;
	assign rvalid = state_reg.rvalid;
	assign rdata = state_reg.rdata;
	assign rresp = state_reg.rresp;
	assign sys_src_sel = state_reg.active;
	assign sys_clk_gate = state_reg.sys_clk_gate;
	assign int_osc_src = state_reg.int_osc_src;
	assign int_div_shift = state_reg.int_div_shift;
	assign pll_select = state_reg.pll_select;
	assign clkout_enable = state_reg.clkout_enable;
	assign sec_osc_enable = state_reg.sec_osc_enable;
	assign primary_drive = state_reg.primary_drive_on;
	assign wdog_lf_select = 1'b1;
	assign idle_entry = state_reg.idle_entry;
	assign sleep_entry = state_reg.sleep_entry;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_sel_primary: assert property ($rose(aresetn)
		|-> state_reg.sysclk_sel == 2'h0 && state_reg.int_freq_sel == 3'h3
		&& state_reg.primary_drive_on)
		else $error("control fields not at reset values");
	a_switch_no_glitch: assert property ($changed(state_reg.active) && $past(aresetn)
		|-> !sys_clk_gate [*3])
		else $error("clock gate open across a source change");
	a_switch_bounded: assert property (state_reg.state == ST_RUN && src_ready
		&& state_reg.active != desired && !$changed(desired)
		|-> ##[1:12] state_reg.active == desired)
		else $error("source switch did not complete");
	a_freq_immediate: assert property ($changed(state_reg.int_freq_sel)
		&& state_reg.int_freq_sel == 3'h7 |=> int_div_shift == 4'h0)
		else $error("internal frequency change not applied");
	a_lowfreq_lf: assert property (state_reg.int_freq_sel == 3'h0
		&& !state_reg.int_src_sel |=> int_osc_src == INT_LF)
		else $error("lf_osc not chosen for code 000");
	a_mf_subst: assert property (state_reg.mf_select
		&& state_reg.int_freq_sel == 3'h1 |=> int_osc_src == INT_MF && int_div_shift == 4'h1)
		else $error("mf_osc not substituted");
	a_idle_pick: assert property (sleep_exec
		|=> idle_entry == $past(state_reg.idle_enable) && sleep_entry != idle_entry)
		else $error("wrong power mode on sleep");
	a_sec_enable: assert property (state_reg.sec_osc_go |=> sec_osc_enable)
		else $error("secondary oscillator not enabled");
	a_failsafe: assert property (state_reg.fail_flag |-> ##[0:12] sys_src_sel == SRC_INT)
		else $error("fail-safe did not move to internal block");
	a_ost_wait: assert property ($rose(state_reg.ost_done) && mode_needs_ost(mode)
		|-> $past(state_reg.ost_cnt) == 11'(OST_COUNT - 1))
		else $error("startup timer ended early");

endmodule : system_clock_select_control
